/* uhl_top.sv */
// Purpose: Host serial port with flow control and the device reset sources.
// Assumes: One 20 MHz clock; software on a plain address/strobe register port.
// Notes:   sys_reset is the device-wide reset; pins float while it is high.
`default_nettype none
module uhl_top
  import uhl_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  input  wire logic        uart_rx,
  output var  logic        uart_tx,
  output var  logic        uart_tx_oe_n,
  input  wire logic        cts_n,
  output var  logic        rts_n,
  output var  logic        rts_oe_n,
  input  wire logic        external_reset_n,
  output var  logic        sys_reset,
  output var  logic        general_io_line_pd
);
  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  logic rx_s;
  logic cts_n_s;
  logic ext_n_s;

  uhl_sync #(.RST_VAL(1'b1)) u_sync_rx  (.core_clk(core_clk), .reset_n(reset_n),
    .clk_en(clk_en), .async_in(uart_rx), .sync_out(rx_s));
  uhl_sync #(.RST_VAL(1'b1)) u_sync_cts (.core_clk(core_clk), .reset_n(reset_n),
    .clk_en(clk_en), .async_in(cts_n), .sync_out(cts_n_s));
  uhl_sync #(.RST_VAL(1'b1)) u_sync_ext (.core_clk(core_clk), .reset_n(reset_n),
    .clk_en(clk_en), .async_in(external_reset_n), .sync_out(ext_n_s));

  //////////////////////////////////////////////////////////////////////////////
  // State declarations.
  uhl_cfg_s    cfg_r, cfg_nxt;
  logic [15:0] baud_r, baud_nxt;
  logic [7:0]  tx_hold_r, tx_hold_nxt;
  logic        tx_pend_r, tx_pend_nxt;
  logic [11:0] tx_sh_r, tx_sh_nxt;
  logic [3:0]  tx_left_r, tx_left_nxt;
  logic [15:0] tx_cnt_r, tx_cnt_nxt;
  uhl_rx_e     rx_st_r, rx_st_nxt;
  logic [15:0] rx_cnt_r, rx_cnt_nxt;
  logic [2:0]  rx_idx_r, rx_idx_nxt;
  logic [7:0]  rx_sh_r, rx_sh_nxt;
  logic [7:0]  rx_data_r, rx_data_nxt;
  logic        rx_valid_r, rx_valid_nxt;
  logic        par_err_r, par_err_nxt;
  logic        frm_err_r, frm_err_nxt;
  logic        ovr_r, ovr_nxt;
  logic [15:0] brk_cyc_r, brk_cyc_nxt;
  logic [3:0]  brk_bits_r, brk_bits_nxt;
  logic        wd_en_r, wd_en_nxt;
  logic [23:0] wd_load_r, wd_load_nxt;
  logic [23:0] wd_cnt_r, wd_cnt_nxt;
  logic [9:0]  lf_cnt_r, lf_cnt_nxt;
  logic [7:0]  ext_ticks_r, ext_ticks_nxt;
  logic        ext_fired_r, ext_fired_nxt;
  uhl_cause_s  cause_r, cause_nxt;
  logic [4:0]  hold_r, hold_nxt;
  logic [31:0] rdata_nxt;
  logic        tx_nxt, rts_n_nxt;
  logic        ev_brk, ev_wd, ev_ext;
  logic        wr_tx, rd_rx, frame_par;
  logic [3:0]  frame_bits;

  assign wr_tx      = reg_wr && (reg_addr == REG_TXDATA);
  assign rd_rx      = reg_rd && (reg_addr == REG_RXDATA);
  assign frame_par  = (cfg_r.parity == PAR_ODD) || (cfg_r.parity == PAR_EVEN);
  assign frame_bits = 4'd10 + {3'd0, frame_par} + {3'd0, cfg_r.two_stop};

  //////////////////////////////////////////////////////////////////////////////
  // Register writes and read data; an internal reset returns them to defaults.
  always_comb begin
    cfg_nxt   = cfg_r;
    baud_nxt  = baud_r;
    wd_en_nxt = wd_en_r;
    wd_load_nxt = wd_load_r;
    rdata_nxt = 32'h00000000;
    if (sys_reset) begin
      cfg_nxt     = '0;
      baud_nxt    = BAUD_DIV_RST;
      wd_en_nxt   = 1'b0;
      wd_load_nxt = WDOG_LOAD_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: begin
          cfg_nxt.flow_en  = reg_wdata[CTRL_FLOW_BIT];
          cfg_nxt.parity   = uhl_par_e'(reg_wdata[CTRL_PAR_LSB +: 2]);
          cfg_nxt.two_stop = reg_wdata[CTRL_STOP2_BIT];
        end
        REG_BAUD: begin
          if (reg_wdata[15:0] < BAUD_DIV_MIN) baud_nxt = BAUD_DIV_MIN;
          else if (reg_wdata[15:0] > BAUD_DIV_MAX) baud_nxt = BAUD_DIV_MAX;
          else baud_nxt = reg_wdata[15:0];
        end
        REG_WDOG: begin
          wd_en_nxt   = reg_wdata[WDOG_EN_BIT];
          wd_load_nxt = reg_wdata[WDOG_LOAD_LSB +: 24];
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:   rdata_nxt = {28'd0, cfg_r.two_stop, cfg_r.parity, cfg_r.flow_en};
        REG_BAUD:   rdata_nxt = {16'd0, baud_r};
        REG_RXDATA: rdata_nxt = {24'd0, rx_data_r};
        REG_STATUS: rdata_nxt = {27'd0, frm_err_r, ovr_r, par_err_r, rx_valid_r,
                                 tx_pend_r | (tx_left_r != 4'd0)};
        REG_WDOG:   rdata_nxt = {wd_load_r, 7'd0, wd_en_r};
        REG_CAUSE:  rdata_nxt = {29'd0, cause_r};
        default:    rdata_nxt = 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmitter: one shift register holds start, data, parity and stop bits.
  always_comb begin
    tx_hold_nxt = tx_hold_r;
    tx_pend_nxt = tx_pend_r;
    tx_sh_nxt   = tx_sh_r;
    tx_left_nxt = tx_left_r;
    tx_cnt_nxt  = tx_cnt_r;
    if (sys_reset) begin
      tx_pend_nxt = 1'b0;
      tx_left_nxt = 4'd0;
      tx_sh_nxt   = 12'hFFF;
    end else begin
      if (wr_tx && !tx_pend_r) begin
        tx_hold_nxt = reg_wdata[7:0];
        tx_pend_nxt = 1'b1;
      end
      if (tx_left_r == 4'd0) begin
        // A new frame starts only while clear-to-send is low, if enabled.
        if (tx_pend_r && (!cfg_r.flow_en || !cts_n_s)) begin
          tx_sh_nxt = frame_par ?
            {2'b11, (cfg_r.parity == PAR_ODD) ? ~^tx_hold_r : ^tx_hold_r, tx_hold_r, 1'b0} :
            {3'b111, tx_hold_r, 1'b0};
          tx_left_nxt = frame_bits;
          tx_cnt_nxt  = baud_r - 16'd1;
          tx_pend_nxt = 1'b0;
        end
      end else if (tx_cnt_r == 16'd0) begin
        tx_sh_nxt   = {1'b1, tx_sh_r[11:1]};
        tx_left_nxt = tx_left_r - 4'd1;
        tx_cnt_nxt  = baud_r - 16'd1;
      end else begin
        tx_cnt_nxt = tx_cnt_r - 16'd1;
      end
    end
    tx_nxt = (tx_left_nxt == 4'd0) ? 1'b1 : tx_sh_nxt[0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receiver: samples each bit at its middle.
  always_comb begin
    rx_st_nxt    = rx_st_r;
    rx_cnt_nxt   = rx_cnt_r;
    rx_idx_nxt   = rx_idx_r;
    rx_sh_nxt    = rx_sh_r;
    rx_data_nxt  = rx_data_r;
    rx_valid_nxt = rx_valid_r & ~rd_rx;
    par_err_nxt  = par_err_r & ~rd_rx;
    frm_err_nxt  = frm_err_r & ~rd_rx;
    ovr_nxt      = ovr_r & ~rd_rx;
    if (sys_reset) begin
      rx_st_nxt    = RX_IDLE;
      rx_valid_nxt = 1'b0;
      par_err_nxt  = 1'b0;
      frm_err_nxt  = 1'b0;
      ovr_nxt      = 1'b0;
    end else begin
      case (rx_st_r)
        RX_IDLE: if (!rx_s) begin
          rx_st_nxt  = RX_START;
          rx_cnt_nxt = {1'b0, baud_r[15:1]};
        end
        default: if (rx_cnt_r != 16'd0) begin
          rx_cnt_nxt = rx_cnt_r - 16'd1;
        end else begin
          rx_cnt_nxt = baud_r - 16'd1;
          case (rx_st_r)
            RX_START: begin
              rx_st_nxt  = rx_s ? RX_IDLE : RX_DATA;
              rx_idx_nxt = 3'd0;
            end
            RX_DATA: begin
              rx_sh_nxt  = {rx_s, rx_sh_r[7:1]};
              rx_idx_nxt = rx_idx_r + 3'd1;
              if (rx_idx_r == 3'(DATA_BITS - 1)) rx_st_nxt = frame_par ? RX_PAR : RX_STOP;
            end
            RX_PAR: begin
              // Set wins over the read that clears it.
              if (rx_s != ((cfg_r.parity == PAR_ODD) ? ~^rx_sh_r : ^rx_sh_r))
                par_err_nxt = 1'b1;
              rx_st_nxt = RX_STOP;
            end
            RX_STOP: begin
              if (!rx_s) frm_err_nxt = 1'b1;
              if (rx_valid_r && !rd_rx) ovr_nxt = 1'b1;
              rx_data_nxt  = rx_sh_r;
              rx_valid_nxt = 1'b1;
              rx_st_nxt    = RX_IDLE;
            end
            default: rx_st_nxt = RX_IDLE;
          endcase
        end
      endcase
    end
    // Ask the host to hold off while the one-character buffer is full.
    rts_n_nxt = cfg_r.flow_en ? rx_valid_nxt : 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Break: line low for more bit times than a whole frame holds.
  always_comb begin
    brk_cyc_nxt  = brk_cyc_r;
    brk_bits_nxt = brk_bits_r;
    ev_brk       = 1'b0;
    if (rx_s || sys_reset) begin
      brk_cyc_nxt  = 16'd0;
      brk_bits_nxt = 4'd0;
    end else if (brk_cyc_r >= baud_r - 16'd1) begin
      brk_cyc_nxt = 16'd0;
      if (brk_bits_r == frame_bits) ev_brk = 1'b1;
      else brk_bits_nxt = brk_bits_r + 4'd1;
    end else begin
      brk_cyc_nxt = brk_cyc_r + 16'd1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog: counts down while armed; a kick reloads it.
  always_comb begin
    wd_cnt_nxt = wd_cnt_r;
    ev_wd      = 1'b0;
    if (sys_reset || !wd_en_r) begin
      wd_cnt_nxt = wd_load_nxt;                                           // Arming takes the new reload.
    end else if (reg_wr && (reg_addr == REG_WDOG_KICK)) begin
      wd_cnt_nxt = wd_load_r;
    end else if (wd_cnt_r == 24'd0) begin
      ev_wd = 1'b1;
    end else begin
      wd_cnt_nxt = wd_cnt_r - 24'd1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset pin filter: sampled once per slow-oscillator tick; one event per low.
  always_comb begin
    lf_cnt_nxt    = (lf_cnt_r == 10'(LF_TICK_CYC - 1)) ? 10'd0 : lf_cnt_r + 10'd1;
    ext_ticks_nxt = ext_ticks_r;
    ext_fired_nxt = ext_fired_r;
    ev_ext        = 1'b0;
    if (lf_cnt_r == 10'd0) begin
      if (ext_n_s) begin
        ext_ticks_nxt = 8'd0;
        ext_fired_nxt = 1'b0;
      end else if (!ext_fired_r) begin
        if (ext_ticks_r == 8'(EXT_FILT_TICKS - 1)) begin
          ev_ext        = 1'b1;
          ext_fired_nxt = 1'b1;
        end else begin
          ext_ticks_nxt = ext_ticks_r + 8'd1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset sequencer and cause flags; a new cause wins over a clearing write.
  always_comb begin
    hold_nxt  = (hold_r != 5'd0) ? hold_r - 5'd1 : 5'd0;
    cause_nxt = cause_r;
    if (reg_wr && (reg_addr == REG_CAUSE)) begin
      cause_nxt = cause_r & ~uhl_cause_s'(reg_wdata[CAUSE_EXT_BIT:CAUSE_BRK_BIT]);
    end
    if (ev_brk) cause_nxt.brk = 1'b1;
    if (ev_wd) cause_nxt.wdog = 1'b1;
    if (ev_ext) cause_nxt.ext = 1'b1;
    if (ev_brk || ev_wd || ev_ext) hold_nxt = 5'(RST_HOLD_CYC);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register every group; clk_en low freezes all of it.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= '0;  baud_r <= BAUD_DIV_RST;  wd_en_r <= 1'b0;  wd_load_r <= WDOG_LOAD_RST;
      reg_rdata <= 32'h00000000;
      tx_hold_r <= 8'h00;  tx_pend_r <= 1'b0;  tx_sh_r <= 12'hFFF;
      tx_left_r <= 4'h0;  tx_cnt_r <= 16'h0000;
      rx_st_r <= RX_IDLE;  rx_cnt_r <= 16'h0000;  rx_idx_r <= 3'h0;  rx_sh_r <= 8'h00;
      rx_data_r <= 8'h00;  rx_valid_r <= 1'b0;
      par_err_r <= 1'b0;  frm_err_r <= 1'b0;  ovr_r <= 1'b0;
      brk_cyc_r <= 16'h0000;  brk_bits_r <= 4'h0;  wd_cnt_r <= WDOG_LOAD_RST;
      lf_cnt_r <= 10'h000;  ext_ticks_r <= 8'h00;  ext_fired_r <= 1'b0;
      cause_r <= '0;  hold_r <= 5'h00;
      uart_tx <= 1'b1;  rts_n <= 1'b1;
      sys_reset <= 1'b1;  uart_tx_oe_n <= 1'b1;  rts_oe_n <= 1'b1;
      general_io_line_pd <= 1'b1;
    end else if (clk_en) begin
      cfg_r <= cfg_nxt;  baud_r <= baud_nxt;  wd_en_r <= wd_en_nxt;  wd_load_r <= wd_load_nxt;
      reg_rdata <= rdata_nxt;
      tx_hold_r <= tx_hold_nxt;  tx_pend_r <= tx_pend_nxt;  tx_sh_r <= tx_sh_nxt;
      tx_left_r <= tx_left_nxt;  tx_cnt_r <= tx_cnt_nxt;
      rx_st_r <= rx_st_nxt;  rx_cnt_r <= rx_cnt_nxt;  rx_idx_r <= rx_idx_nxt;
      rx_sh_r <= rx_sh_nxt;  rx_data_r <= rx_data_nxt;  rx_valid_r <= rx_valid_nxt;
      par_err_r <= par_err_nxt;  frm_err_r <= frm_err_nxt;  ovr_r <= ovr_nxt;
      brk_cyc_r <= brk_cyc_nxt;  brk_bits_r <= brk_bits_nxt;  wd_cnt_r <= wd_cnt_nxt;
      lf_cnt_r <= lf_cnt_nxt;  ext_ticks_r <= ext_ticks_nxt;  ext_fired_r <= ext_fired_nxt;
      cause_r <= cause_nxt;  hold_r <= hold_nxt;
      uart_tx <= tx_nxt;  rts_n <= rts_n_nxt;
      sys_reset <= (hold_nxt != 5'd0);
      // While reset stands, outputs float and general lines are pulled down.
      uart_tx_oe_n       <= (hold_nxt != 5'd0);
      rts_oe_n           <= (hold_nxt != 5'd0);
      general_io_line_pd <= (hold_nxt != 5'd0);
    end
  end
endmodule
`default_nettype wire

/* uhl_pkg.sv */
// Purpose: Shared constants and carrier types of the host serial link with reset.
// Assumes: Core clock of 20 MHz; registers on a plain strobe port, one word each.
// Notes:   Every offset and timing count lives here; STATUS field positions and some reset values sit in uhl_top.
`default_nettype none
package uhl_pkg;
  //////////////////////////////////////////////////////////////////////////////
  // Clock and timing.
  localparam int CLK_PERIOD_NS   = 50;
  localparam int LF_PERIOD_NS    = 31250;                       // Slow oscillator period.
  localparam int LF_TICK_CYC     = LF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int EXT_MIN_US      = 1500;                        // Earliest reset after pin low.
  localparam int EXT_MAX_US      = 4000;                        // Latest reset after pin low.
  localparam int EXT_FILT_TICKS  = (EXT_MIN_US * 1000 + LF_PERIOD_NS - 1) / LF_PERIOD_NS + 1;
  localparam int RST_HOLD_CYC    = 16;                          // Length of the internal reset.
  localparam int MIN_BAUD        = 1200;
  localparam int MAX_BAUD        = 3000000;
  localparam int DATA_BITS       = 8;

  //////////////////////////////////////////////////////////////////////////////
  // Register indices on the 4-bit address port.
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_BAUD      = 4'h1;
  localparam logic [3:0] REG_TXDATA    = 4'h2;
  localparam logic [3:0] REG_RXDATA    = 4'h3;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam logic [3:0] REG_WDOG      = 4'h5;
  localparam logic [3:0] REG_WDOG_KICK = 4'h6;
  localparam logic [3:0] REG_CAUSE     = 4'h7;

  // Field positions.
  localparam int CTRL_FLOW_BIT  = 0;
  localparam int CTRL_PAR_LSB   = 1;
  localparam int CTRL_STOP2_BIT = 3;
  localparam int WDOG_EN_BIT    = 0;
  localparam int WDOG_LOAD_LSB  = 8;
  localparam int CAUSE_BRK_BIT  = 0;
  localparam int CAUSE_WDOG_BIT = 1;
  localparam int CAUSE_EXT_BIT  = 2;

  // Reset values.
  localparam logic [15:0] BAUD_DIV_RST = 16'h00AD;              // About 115200 baud.
  localparam logic [23:0] WDOG_LOAD_RST = 24'hFFFFFF;

  // Baud divisor limits in core cycles per bit.
  localparam logic [15:0] BAUD_DIV_MIN = 16'(CLK_PERIOD_NS * 0 + 1000000000 / CLK_PERIOD_NS
                                             / MAX_BAUD);
  localparam logic [15:0] BAUD_DIV_MAX = 16'(1000000000 / CLK_PERIOD_NS / MIN_BAUD);

  //////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [1:0] { PAR_NONE, PAR_ODD, PAR_EVEN, PAR_RSVD } uhl_par_e;

  typedef struct packed {
    logic     two_stop;
    uhl_par_e parity;
    logic     flow_en;
  } uhl_cfg_s;

  typedef struct packed {
    logic ext;
    logic wdog;
    logic brk;
  } uhl_cause_s;

  typedef enum { RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP } uhl_rx_e;
endpackage
`default_nettype wire

/* uhl_sync.sv */
// Purpose: Three-stage synchroniser for a level from outside the clock domain.
// Assumes: The level is slow against the core clock.
// Notes:   The output follows only when the second and third stages agree.
`default_nettype none
module uhl_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  input  wire logic async_in,
  output var  logic sync_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic out_nxt;

  // The first stage feeds only the second one.
  always_comb begin
    out_nxt = (s2_r == s3_r) ? s3_r : sync_out;
  end

  // Register the chain and the settled level.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r     <= RST_VAL;
      s2_r     <= RST_VAL;
      s3_r     <= RST_VAL;
      sync_out <= RST_VAL;
    end else if (clk_en) begin
      s1_r     <= async_in;
      s2_r     <= s1_r;
      s3_r     <= s2_r;
      sync_out <= out_nxt;
    end
  end
endmodule
`default_nettype wire

/* uhl_checker.sv */
// Purpose: Port checks of the host serial link and reset outputs.
// Assumes: clk_en low only briefly, with no event pending; a single clock domain.
// Notes:   Bound to uhl_top after the module.
`default_nettype none
module uhl_checker
  import uhl_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        uart_tx,
  input wire logic        uart_tx_oe_n,
  input wire logic        rts_oe_n,
  input wire logic        external_reset_n,
  input wire logic        sys_reset,
  input wire logic        general_io_line_pd
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [16:0] low_r, low_nxt;
  logic        fired_r, fired_nxt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Counts pin-low cycles and notes whether a reset followed in that low period.
  always_comb begin
    low_nxt   = external_reset_n ? 17'h0 : low_r + 17'(low_r != 17'h1FFFF);
    fired_nxt = !external_reset_n && (fired_r || sys_reset);
  end
  // Registers the helper state.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_r   <= 17'h0;
      fired_r <= 1'b0;
    end else begin
      low_r   <= low_nxt;
      fired_r <= fired_nxt;
    end
  end
  ////////////////////////////////////////
  a_float_in_reset: assert property (
    sys_reset && $past(sys_reset) |-> uart_tx_oe_n && rts_oe_n && general_io_line_pd)
    else $error("pins driven during reset");
  a_drive_out_reset: assert property (
    !sys_reset && !$past(sys_reset) |-> !uart_tx_oe_n && !rts_oe_n && !general_io_line_pd)
    else $error("pins floating outside reset");
  a_reset_length: assert property (
    $rose(sys_reset) |-> sys_reset[*8] ##1 sys_reset[*8] ##1 !sys_reset)
    else $error("internal reset not 16 cycles");
  a_tx_idle_after: assert property (
    $fell(sys_reset) |-> uart_tx[*2])
    else $error("transmit line not idle after reset");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  a_ext_not_early: assert property (
    $rose(sys_reset) && !external_reset_n |-> low_r >= 17'd30000)
    else $error("pin reset too early");
  a_ext_not_late: assert property (
    low_r == 17'd80000 |-> fired_r)
    else $error("pin reset too late");
  a_oe_pair: assert property (
    uart_tx_oe_n == rts_oe_n)
    else $error("output enables disagree");
  c_ext_reset: cover property ($rose(sys_reset) && !external_reset_n);
  c_int_reset: cover property ($rose(sys_reset) && external_reset_n);
  c_read_data: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule
bind uhl_top uhl_checker u_chk (.core_clk(core_clk), .reset_n(reset_n), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .uart_tx(uart_tx), .uart_tx_oe_n(uart_tx_oe_n),
  .rts_oe_n(rts_oe_n), .external_reset_n(external_reset_n), .sys_reset(sys_reset),
  .general_io_line_pd(general_io_line_pd));
`default_nettype wire

/* uhl_host_model.sv */
// Purpose: Host microcontroller side of the serial link and reset pin.
// Assumes: Bit time given in core cycles by the caller.
// Notes:   Receive line idles high between frames.
`default_nettype none
module uhl_host_model (
  input  wire logic core_clk,
  input  wire logic uart_tx,
  output var  logic uart_rx,
  output var  logic cts_n,
  output var  logic external_reset_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle levels of the host outputs.
  initial begin
    uart_rx          = 1'b1;
    cts_n            = 1'b0;
    external_reset_n = 1'b1;
  end
  // Sends start, 8 data bits LSB first, optional parity and one stop bit.
  task automatic send_frame(input logic [7:0] d, input int div, input logic [1:0] par);
    logic [10:0] f;
    int          n;
    n = (par == 2'd1 || par == 2'd2) ? 11 : 10;
    f = (n == 11) ? {1'b1, (par == 2'd1) ^ (^d), d, 1'b0} : {2'b11, d, 1'b0};
    for (int i = 0; i < n; i++) begin
      uart_rx <= f[i];
      repeat (div) @(posedge core_clk);
    end
  endtask
  // Holds the receive line low for a number of cycles.
  task automatic hold_low(input int c);
    uart_rx <= 1'b0;
    repeat (c) @(posedge core_clk);
    uart_rx <= 1'b1;
  endtask
  // Samples one frame from the transmit line at mid-bit.
  task automatic recv_frame(input int div, input logic [1:0] par, input logic two,
                            output logic [7:0] d, output logic pb, output logic ok);
    int t;
    t  = 0;
    d  = 8'h00;
    pb = 1'b0;
    while (uart_tx !== 1'b0 && t < 5000) begin
      @(posedge core_clk);
      t++;
    end
    repeat (div / 2) @(posedge core_clk);
    ok = (uart_tx === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge core_clk);
      d[i] = uart_tx;
    end
    if (par == 2'd1 || par == 2'd2) begin
      repeat (div) @(posedge core_clk);
      pb = uart_tx;
    end
    for (int i = 0; i < 1 + int'(two); i++) begin
      repeat (div) @(posedge core_clk);
      ok = ok && (uart_tx === 1'b1);
    end
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench of the host serial link with reset.
// Assumes: clk_en high except in one freeze check; host model on the serial pins.
// Notes:   The pin reset scenario runs about 80k cycles.
`default_nettype none
module tb_top
  import uhl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, reset_n, clk_en, reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic        uart_rx, uart_tx, uart_tx_oe_n, cts_n, rts_n, rts_oe_n;
  logic        ext_n, sys_reset, general_io_line_pd;
  int          fail_count, cmp_count, rst_seen;
  uhl_top dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .uart_rx(uart_rx), .uart_tx(uart_tx), .uart_tx_oe_n(uart_tx_oe_n), .cts_n(cts_n),
    .rts_n(rts_n), .rts_oe_n(rts_oe_n), .external_reset_n(ext_n), .sys_reset(sys_reset),
    .general_io_line_pd(general_io_line_pd));
  uhl_host_model host (.core_clk(core_clk), .uart_tx(uart_tx), .uart_rx(uart_rx),
    .cts_n(cts_n), .external_reset_n(ext_n));
  ////////////////////////////////////////
  // Clock, reset event count and watchdog.
  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;
  always @(posedge sys_reset) rst_seen++;
  initial begin
    #(95000 * 50);
    fail_count++;
    complete_run();
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic check_rd(input string what, input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(what, exp, reg_rdata);
  endtask
  ////////////////////////////////////////
  // Transmit in every parity and stop setting.
  task automatic t_tx();
    logic [7:0] d, e;
    logic       p, ok;
    wr(REG_BAUD, 32'h8);
    for (int k = 0; k < 4; k++) begin
      e = 8'h5A ^ 8'(k);
      wr(REG_CTRL, 32'(k << 1) | 32'((k & 1) << 3));
      fork
        wr(REG_TXDATA, 32'(e));
        host.recv_frame(8, 2'(k), k[0], d, p, ok);
      join
      check("tx data", 32'(e), 32'(d));
      check("tx frame", 32'h1, 32'(ok));
      if (k == 1 || k == 2) check("tx parity", 32'((k == 1) ^ (^e)), 32'(p));
    end
  endtask
  // Receive with good and bad parity.
  task automatic t_rx();
    wr(REG_CTRL, 32'h2);
    host.send_frame(8'h3C, 8, 2'd1);
    idle(20);
    check_rd("rx status", REG_STATUS, 32'h2);
    check_rd("rx data", REG_RXDATA, 32'h3C);
    check_rd("rx status clear", REG_STATUS, 32'h0);
    host.send_frame(8'h3C, 8, 2'd2);
    idle(20);
    check_rd("parity error", REG_STATUS, 32'h6);
    check_rd("rx data again", REG_RXDATA, 32'h3C);
  endtask
  // Flow control holds transmit until clear and raises request while full.
  task automatic t_flow();
    logic [7:0] d;
    logic       p, ok;
    wr(REG_CTRL, 32'h1);
    host.cts_n <= 1'b1;
    idle(5);
    wr(REG_TXDATA, 32'h81);
    idle(40);
    check("tx held", 32'h1, 32'(uart_tx));
    check("rts ready", 32'h0, 32'(rts_n));
    host.send_frame(8'h11, 8, 2'd0);
    idle(20);
    check("rts full", 32'h1, 32'(rts_n));
    check_rd("flow rx", REG_RXDATA, 32'h11);
    idle(2);
    check("rts again", 32'h0, 32'(rts_n));
    fork
      host.cts_n <= 1'b0;
      host.recv_frame(8, 2'd0, 1'b0, d, p, ok);
    join
    check("flow tx", 32'h81, 32'(d));
  endtask
  // Short low is a character, long low is a break.
  task automatic t_break();
    int n;
    n = rst_seen;
    wr(REG_CTRL, 32'h0);
    host.hold_low(70);
    idle(120);
    check("short low", 32'(n), 32'(rst_seen));
    host.hold_low(100);
    idle(30);
    check("break reset", 32'(n + 1), 32'(rst_seen));
    check_rd("break cause", REG_CAUSE, 32'h1);
    wr(REG_CAUSE, 32'h1);
    check_rd("cause clear", REG_CAUSE, 32'h0);
  endtask
  // Watchdog kicked once, then left to expire.
  task automatic t_wdog();
    int n;
    n = rst_seen;
    wr(REG_WDOG, 32'h0000C801);
    idle(150);
    wr(REG_WDOG_KICK, 32'h0);
    idle(150);
    check("kicked", 32'(n), 32'(rst_seen));
    idle(100);
    check("expired", 32'(n + 1), 32'(rst_seen));
    check_rd("wdog cause", REG_CAUSE, 32'h2);
    wr(REG_CAUSE, 32'h2);
  endtask
  // Pin glitch is filtered; a held pin resets inside the window.
  task automatic t_ext();
    int n;
    n = rst_seen;
    host.external_reset_n <= 1'b0;
    idle(1000);
    host.external_reset_n <= 1'b1;
    idle(700);
    check("glitch", 32'(n), 32'(rst_seen));
    host.external_reset_n <= 1'b0;
    idle(30000);
    check("pin early", 32'(n), 32'(rst_seen));
    idle(50000);
    check("pin late", 32'(n + 1), 32'(rst_seen));
    idle(10);
    host.external_reset_n <= 1'b1;
    check_rd("pin cause", REG_CAUSE, 32'h4);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    reset_n   = 1'b0;
    clk_en    = 1'b1;
    reg_addr  = 4'h0;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    idle(2);
    check("pins in reset", 32'h7, 32'({general_io_line_pd, uart_tx_oe_n, rts_oe_n}));
    reset_n <= 1'b1;
    check_rd("baud reset", REG_BAUD, 32'(BAUD_DIV_RST));
    check_rd("ctrl reset", REG_CTRL, 32'h0);
    check_rd("wdog reset", REG_WDOG, 32'hFFFFFF00);
    wr(4'h9, 32'hFF);
    check_rd("unmapped", 4'h9, 32'h0);
    // A write while the clock enable is low must leave no trace.
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(REG_CTRL, 32'h8);
    clk_en <= 1'b1;
    check_rd("ctrl frozen", REG_CTRL, 32'h0);
    t_tx();
    t_rx();
    t_flow();
    t_break();
    t_wdog();
    t_ext();
    complete_run();
  end
endmodule
`default_nettype wire
